// *** src/swl_pkg.sv ***
package swl_pkg;
  // identification code layout
  localparam int FAMILY_LSB = 0;
  localparam int FAMILY_W = 8;
  localparam int SERIAL_LSB = 8;
  localparam int SERIAL_W = 48;
  localparam int CHECK_LSB = 56;
  localparam int CHECK_W = 8;
  localparam int DATA_BITS = 56;
  localparam int ROM_BITS = 64;
  // x^8 + x^5 + x^4 + 1, reflected feedback positions
  localparam logic [7:0] CRC_TAPS = 8'h8c;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // arbitrary neutral identity values
  localparam logic [7:0] FAMILY_DEFAULT = 8'h5a;
  localparam logic [47:0] SERIAL_DEFAULT = 48'h0123_4567_89ab;
  // rom function commands
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_MATCH_ID = 8'h55;
  localparam logic [7:0] CMD_SEARCH_ID = 8'hf0;
  localparam logic [7:0] CMD_COND_SEARCH = 8'hec;
  localparam logic [7:0] CMD_SKIP_ID = 8'hcc;
  localparam logic [7:0] CMD_OD_SKIP = 8'h3c;
  localparam logic [7:0] CMD_OD_MATCH = 8'h69;
  localparam logic [7:0] CMD_RESUME = 8'ha5;
  // memory and control commands
  localparam logic [7:0] CMD_WRITE_PAD = 8'h0f;
  localparam logic [7:0] CMD_READ_PAD = 8'haa;
  localparam logic [7:0] CMD_COPY_PAD = 8'h99;
  localparam logic [7:0] CMD_READ_MEM = 8'h69;
  // address map, byte addresses
  localparam logic [15:0] SRAM_BASE = 16'h0000;
  localparam logic [15:0] SRAM_END = 16'h01ff;
  localparam logic [15:0] REGP_BASE = 16'h0200;
  localparam logic [15:0] REGP_END = 16'h023f;
  localparam logic [15:0] RO_REG_BASE = 16'h020c;
  localparam logic [15:0] RO_REG_END = 16'h020f;
  localparam logic [15:0] STAT_BASE = 16'h0214;
  localparam logic [15:0] STAT_END = 16'h0215;
  localparam logic [15:0] TSTAMP_BASE = 16'h0219;
  localparam logic [15:0] TSTAMP_END = 16'h0227;
  localparam logic [15:0] PWD_BASE = 16'h0228;
  localparam logic [15:0] PWD_END = 16'h0237;
  localparam logic [15:0] CAL_BASE = 16'h0240;
  localparam logic [15:0] CAL_END = 16'h027f;
  localparam logic [15:0] LOG_BASE = 16'h1000;
  localparam logic [15:0] LOG_END = 16'h2fff;
  localparam int PAD_BYTES = 32;
  localparam int FIFO_DEPTH = 4;
  localparam logic [7:0] FILL_BYTE = 8'hff;
endpackage

// *** src/swl_if.sv ***
`timescale 1ns/1ps
interface swl_if;
  // byte stream master to device
  logic [7:0] m2d_data;
  logic m2d_valid;
  logic m2d_ready;
  // byte stream device to master
  logic [7:0] d2m_data;
  logic d2m_valid;
  logic d2m_ready;
  // bus reset from master
  logic bus_reset;
  logic overdrive;
  modport dev (input m2d_data, input m2d_valid, output m2d_ready, output d2m_data,
    output d2m_valid, input d2m_ready, input bus_reset, output overdrive);
  modport mst (output m2d_data, output m2d_valid, input m2d_ready, input d2m_data,
    input d2m_valid, output d2m_ready, output bus_reset, input overdrive);
endinterface

// *** src/swl_fifo.sv ***
`timescale 1ns/1ps
module swl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = swl_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin
      $error("fifo depth must be a power of two");
    end
  end
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } swl_fifo_s;
  swl_fifo_s st_r;
  swl_fifo_s st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic push;
  logic pop;
  logic full;
  logic empty;
  assign full = (st_r.wr[AW] != st_r.rd[AW]) && (st_r.wr[AW-1:0] == st_r.rd[AW-1:0]);
  assign empty = st_r.wr == st_r.rd;
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem_r[st_r.rd[AW-1:0]];
  assign push = i_valid && !full;
  assign pop = i_ready && !empty;
  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (pop)
    begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
    if (push)
    begin
      mem_r[st_r.wr[AW-1:0]] <= i_data;
    end
  end
endmodule

// *** src/swl_device.sv ***
`timescale 1ns/1ps
module swl_device #(
  parameter logic [7:0] FAMILY = swl_pkg::FAMILY_DEFAULT,
  parameter logic [47:0] SERIAL = swl_pkg::SERIAL_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_reset,
  swl_if.dev bus,
  input wire logic i_mission,
  output logic o_overdrive,
  output logic o_id_ok,
  output logic o_wr_en,
  output logic [15:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_rd_req,
  output logic [15:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  output logic o_cmd_err
);
  typedef enum logic [2:0] {
    ST_ROM, ST_ROM_TX, ST_IDLE, ST_MCMD, ST_ADDR, ST_PAD, ST_READ
  } swl_st_e;
  typedef struct packed {
    swl_st_e st;
    logic [7:0] crc;
    logic [6:0] bitn;
    logic [2:0] bytn;
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [4:0] padn;
    logic [4:0] padcnt;
    logic od;
    logic ok;
    logic crc_ok;
    logic wr_en;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_req;
    logic err;
    logic [7:0] tx_data;
    logic tx_valid;
    logic copying;
  } swl_dev_s;
  swl_dev_s st_r;
  swl_dev_s st_nxt;
  logic [7:0] pad_r [swl_pkg::PAD_BYTES];
  logic [63:0] id_code;
  logic [7:0] crc_calc;
  logic tx_ready;
  logic [7:0] rx_byte;
  logic rx_fire;
  logic wr_allowed;
  logic rd_hidden;
  logic [15:0] cp_addr;
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = (c >> 1) ^ (fb ? swl_pkg::CRC_TAPS : 8'h00);
  endfunction
  always_comb
  begin
    crc_calc = swl_pkg::CRC_INIT;
    for (int i = 0; i < swl_pkg::DATA_BITS; i++)
      crc_calc = crc_step(crc_calc, id_code[i]);
  end
  assign id_code[swl_pkg::FAMILY_LSB +: swl_pkg::FAMILY_W] = FAMILY;
  assign id_code[swl_pkg::SERIAL_LSB +: swl_pkg::SERIAL_W] = SERIAL;
  assign id_code[swl_pkg::CHECK_LSB +: swl_pkg::CHECK_W] = crc_calc;
  swl_fifo #(.WIDTH(8), .DEPTH(swl_pkg::FIFO_DEPTH)) u_txq (
    .i_clk(i_clk), .i_reset(i_reset || bus.bus_reset),
    .i_data(st_r.tx_data), .i_valid(st_r.tx_valid), .o_ready(tx_ready),
    .o_data(bus.d2m_data), .o_valid(bus.d2m_valid), .i_ready(bus.d2m_ready)
  );
  assign bus.m2d_ready = tx_ready && !st_r.tx_valid && !st_r.copying;
  assign rx_fire = bus.m2d_valid && bus.m2d_ready;
  assign rx_byte = bus.m2d_data;
  assign bus.overdrive = st_r.od;
  assign o_overdrive = st_r.od;
  assign o_id_ok = st_r.ok;
  assign o_wr_en = st_r.wr_en;
  assign o_wr_addr = st_r.wr_addr;
  assign o_wr_data = st_r.wr_data;
  assign o_rd_req = st_r.rd_req;
  assign o_rd_addr = st_r.addr;
  assign o_cmd_err = st_r.err;
  always_comb
  begin
    // target of the scratchpad byte now being copied
    cp_addr = st_r.addr + {11'h000, st_r.padcnt};
    wr_allowed = cp_addr <= swl_pkg::SRAM_END ||
      (cp_addr >= swl_pkg::CAL_BASE && cp_addr <= swl_pkg::CAL_END) ||
      (cp_addr >= swl_pkg::REGP_BASE && cp_addr <= swl_pkg::REGP_END && !i_mission &&
      !(cp_addr >= swl_pkg::RO_REG_BASE && cp_addr <= swl_pkg::RO_REG_END) &&
      !(cp_addr >= swl_pkg::STAT_BASE && cp_addr <= swl_pkg::STAT_END) &&
      !(cp_addr >= swl_pkg::TSTAMP_BASE && cp_addr <= swl_pkg::TSTAMP_END));
    rd_hidden = st_r.addr >= swl_pkg::PWD_BASE && st_r.addr <= swl_pkg::PWD_END;
  end
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tx_valid = 1'b0;
    st_nxt.wr_en = 1'b0;
    st_nxt.rd_req = 1'b0;
    st_nxt.err = 1'b0;
    case (st_r.st)
      ST_ROM:
      begin
        if (rx_fire)
        begin
          st_nxt.cmd = rx_byte;
          st_nxt.bitn = '0;
          st_nxt.crc = swl_pkg::CRC_INIT;
          case (rx_byte)
            swl_pkg::CMD_READ_ID, swl_pkg::CMD_MATCH_ID, swl_pkg::CMD_OD_MATCH:
              st_nxt.st = ST_ROM_TX;
            swl_pkg::CMD_SKIP_ID, swl_pkg::CMD_RESUME:
            begin
              st_nxt.ok = 1'b1;
              st_nxt.st = ST_IDLE;
            end
            swl_pkg::CMD_OD_SKIP:
            begin
              st_nxt.ok = 1'b1;
              st_nxt.od = 1'b1;
              st_nxt.st = ST_IDLE;
            end
            default:
              st_nxt.err = 1'b1;
          endcase
        end
      end
      ST_ROM_TX:
      begin
        // read sends 8 id bytes; match compares 8 received bytes, crc runs over all 64
        if (st_r.cmd == swl_pkg::CMD_READ_ID && tx_ready)
        begin
          st_nxt.tx_data = id_code[{st_r.bitn[5:3], 3'b000} +: 8];
          st_nxt.tx_valid = 1'b1;
          st_nxt.bitn = st_r.bitn + 7'd8;
          if (st_r.bitn == 7'd56)
          begin
            st_nxt.ok = 1'b1;
            st_nxt.st = ST_IDLE;
          end
        end
        else if (st_r.cmd != swl_pkg::CMD_READ_ID && rx_fire)
        begin
          for (int i = 0; i < 8; i++)
            st_nxt.crc = crc_step(st_nxt.crc, rx_byte[i]);
          st_nxt.bitn = st_r.bitn + 7'd8;
          if (rx_byte != id_code[{st_r.bitn[5:3], 3'b000} +: 8])
            st_nxt.crc_ok = 1'b1;
          if (st_r.bitn == 7'd56)
          begin
            // residue must be zero and all bytes matched
            if (!st_r.crc_ok && st_nxt.crc == 8'h00 &&
              rx_byte == id_code[swl_pkg::CHECK_LSB +: 8])
            begin
              st_nxt.ok = 1'b1;
              st_nxt.od = st_r.od || (st_r.cmd == swl_pkg::CMD_OD_MATCH);
              st_nxt.st = ST_IDLE;
            end
            else
            begin
              st_nxt.err = 1'b1;
              st_nxt.st = ST_ROM;
            end
            st_nxt.crc_ok = 1'b0;
          end
        end
      end
      ST_IDLE:
      begin
        if (rx_fire && st_r.ok)
        begin
          st_nxt.cmd = rx_byte;
          st_nxt.bytn = '0;
          st_nxt.st = ST_ADDR;
          if (rx_byte == swl_pkg::CMD_COPY_PAD)
          begin
            st_nxt.copying = 1'b1;
            st_nxt.padcnt = '0;
            st_nxt.st = ST_MCMD;
          end
        end
      end
      ST_ADDR:
      begin
        if (rx_fire)
        begin
          st_nxt.bytn = st_r.bytn + 3'd1;
          if (st_r.bytn == 3'd0)
            st_nxt.addr[7:0] = rx_byte;
          else
          begin
            st_nxt.addr[15:8] = rx_byte;
            st_nxt.padn = '0;
            st_nxt.st = (st_r.cmd == swl_pkg::CMD_WRITE_PAD) ? ST_PAD :
              (st_r.cmd == swl_pkg::CMD_READ_MEM) ? ST_READ : ST_ROM;
            st_nxt.err = st_r.cmd != swl_pkg::CMD_WRITE_PAD &&
              st_r.cmd != swl_pkg::CMD_READ_MEM;
          end
        end
      end
      ST_PAD:
      begin
        if (rx_fire)
          st_nxt.padn = st_r.padn + 5'd1;
      end
      ST_MCMD:
      begin
        // copy pad bytes 0 to padn-1 to target, one per cycle; padn 0 means all 32
        st_nxt.wr_en = wr_allowed;
        st_nxt.wr_data = pad_r[st_r.padcnt];
        st_nxt.wr_addr = cp_addr;
        st_nxt.padcnt = st_r.padcnt + 5'd1;
        if (st_r.padcnt == st_r.padn - 5'd1)
        begin
          st_nxt.copying = 1'b0;
          st_nxt.st = ST_IDLE;
        end
      end
      ST_READ:
      begin
        if (tx_ready)
        begin
          st_nxt.tx_data = rd_hidden ? swl_pkg::FILL_BYTE : i_rd_data;
          st_nxt.tx_valid = 1'b1;
          st_nxt.addr = st_r.addr + 16'd1;
          st_nxt.rd_req = 1'b1;
        end
      end
      default:
        st_nxt.st = ST_ROM;
    endcase
    if (bus.bus_reset)
    begin
      st_nxt.st = ST_ROM;
      st_nxt.ok = 1'b0;
      st_nxt.copying = 1'b0;
      st_nxt.crc_ok = 1'b0;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
    if (st_r.st == ST_PAD && rx_fire)
      pad_r[st_r.padn] <= rx_byte;
  end
endmodule

// *** src/swl_master.sv ***
`timescale 1ns/1ps
module swl_master (
  input wire logic i_clk,
  input wire logic i_reset,
  swl_if.mst bus,
  input wire logic i_bus_reset,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  output logic [7:0] o_crc,
  output logic o_crc_zero,
  input wire logic i_crc_clear
);
  typedef struct packed {
    logic [7:0] crc;
    logic [7:0] rx_data;
    logic rx_valid;
    logic brst;
    logic crc_zero;
  } swl_mst_s;
  swl_mst_s st_r;
  swl_mst_s st_nxt;
  assign bus.m2d_data = i_tx_data;
  assign bus.m2d_valid = i_tx_valid;
  assign o_tx_ready = bus.m2d_ready;
  assign bus.d2m_ready = 1'b1;
  assign bus.bus_reset = st_r.brst;
  assign o_rx_data = st_r.rx_data;
  assign o_rx_valid = st_r.rx_valid;
  assign o_crc = st_r.crc;
  assign o_crc_zero = st_r.crc_zero;
  always_comb
  begin
    logic fb;
    fb = 1'b0;
    st_nxt = st_r;
    st_nxt.brst = i_bus_reset;
    st_nxt.rx_valid = bus.d2m_valid;
    if (bus.d2m_valid)
    begin
      st_nxt.rx_data = bus.d2m_data;
      for (int i = 0; i < 8; i++)
      begin
        fb = st_nxt.crc[0] ^ bus.d2m_data[i];
        st_nxt.crc = (st_nxt.crc >> 1) ^ (fb ? swl_pkg::CRC_TAPS : 8'h00);
      end
    end
    if (i_crc_clear || i_bus_reset)
    begin
      st_nxt.crc = swl_pkg::CRC_INIT;
    end
    st_nxt.crc_zero = st_nxt.crc == 8'h00;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
endmodule

// *** testbench/swl_properties.sv ***
`timescale 1ns/1ps
module swl_properties #(
  parameter logic [7:0] FAMILY = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] m2d_data,
  input wire logic m2d_valid,
  input wire logic m2d_ready,
  input wire logic [7:0] d2m_data,
  input wire logic d2m_valid,
  input wire logic d2m_ready,
  input wire logic bus_reset,
  input wire logic overdrive
);
  logic take;
  logic first_r;
  logic rd_id_r;
  logic od_cmd_r;
  logic any_r;
  logic [7:0] crc_r;
  logic [7:0] crc_nxt;
  logic [3:0] cnt_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  assign take = m2d_valid && m2d_ready;

  // residue over the returned id bytes, lsb first
  always_comb
  begin
    crc_nxt = crc_r;
    for (int i = 0; i < 8; i++)
    begin
      if (crc_nxt[0] ^ d2m_data[i])
        crc_nxt = (crc_nxt >> 1) ^ 8'h8c;
      else
        crc_nxt = crc_nxt >> 1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset || bus_reset)
    begin
      first_r <= 1'b1;
      rd_id_r <= 1'b0;
      crc_r <= 8'h00;
      cnt_r <= 4'h0;
    end
    else
    begin
      if (take)
        first_r <= 1'b0;
      if (take && first_r && m2d_data == swl_pkg::CMD_READ_ID)
        rd_id_r <= 1'b1;
      if (rd_id_r && d2m_valid && d2m_ready && cnt_r < 4'h8)
      begin
        crc_r <= crc_nxt;
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      od_cmd_r <= 1'b0;
      any_r <= 1'b0;
    end
    else
    begin
      if (take)
        any_r <= 1'b1;
      if (take && first_r && (m2d_data == swl_pkg::CMD_OD_SKIP ||
          m2d_data == swl_pkg::CMD_OD_MATCH))
        od_cmd_r <= 1'b1;
    end
  end

  property p_id_answer;
    take && first_r && m2d_data == swl_pkg::CMD_READ_ID |->
      ##[1:4] (d2m_valid && d2m_data == FAMILY);
  endproperty
  a_id_answer: assert property (p_id_answer) else $error("id not answered");

  property p_crc_zero;
    rd_id_r && cnt_r == 4'h8 |-> crc_r == 8'h00;
  endproperty
  a_crc_zero: assert property (p_crc_zero) else $error("id residue nonzero");

  property p_od_hold;
    overdrive |=> overdrive;
  endproperty
  a_od_hold: assert property (p_od_hold) else $error("overdrive dropped");

  property p_od_cause;
    $rose(overdrive) |-> od_cmd_r;
  endproperty
  a_od_cause: assert property (p_od_cause) else $error("overdrive without cmd");

  property p_d2m_hold;
    d2m_valid && !d2m_ready |=> d2m_valid && $stable(d2m_data);
  endproperty
  a_d2m_hold: assert property (p_d2m_hold) else $error("d2m byte changed");

  property p_m2d_hold;
    m2d_valid && !m2d_ready |=> m2d_valid && $stable(m2d_data);
  endproperty
  a_m2d_hold: assert property (p_m2d_hold) else $error("m2d byte changed");

  property p_reset_quiet;
    $fell(i_reset) |-> !d2m_valid && !overdrive;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");

  property p_no_spont;
    d2m_valid |-> any_r;
  endproperty
  a_no_spont: assert property (p_no_spont) else $error("data without cmd");
endmodule

// *** testbench/single_wire_rom_id_crc_tb.sv ***
`timescale 1ns/1ps
module single_wire_rom_id_crc_tb;
  localparam logic [55:0] ID_DATA = {swl_pkg::SERIAL_DEFAULT, swl_pkg::FAMILY_DEFAULT};
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic bus_rst = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic crc_clear = 1'b0;
  logic mission = 1'b0;
  logic tx_ready, rx_valid, crc_zero, overdrive, id_ok, wr_en, rd_req, cmd_err;
  logic [7:0] rx_data, crc, wr_data, rd_data;
  logic [15:0] wr_addr, rd_addr, wr_last;
  logic [63:0] id;
  logic [7:0] rxq[$];
  logic [7:0] mq[$];
  int mismatches = 0;
  int n_tests = 0;
  int n_wr = 0;
  int n_err = 0;

  swl_if bus();
  swl_device swl_device_i (.i_clk(i_clk), .i_reset(i_reset), .bus(bus), .i_mission(mission),
    .o_overdrive(overdrive), .o_id_ok(id_ok), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
    .o_cmd_err(cmd_err));
  swl_master swl_master_i (.i_clk(i_clk), .i_reset(i_reset), .bus(bus),
    .i_bus_reset(bus_rst), .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_crc(crc), .o_crc_zero(crc_zero),
    .i_crc_clear(crc_clear));
  swl_properties #(.FAMILY(swl_pkg::FAMILY_DEFAULT)) swl_properties_i (.i_clk(i_clk),
    .i_reset(i_reset), .m2d_data(bus.m2d_data), .m2d_valid(bus.m2d_valid),
    .m2d_ready(bus.m2d_ready), .d2m_data(bus.d2m_data), .d2m_valid(bus.d2m_valid),
    .d2m_ready(bus.d2m_ready), .bus_reset(bus.bus_reset), .overdrive(bus.overdrive));

  always #2 i_clk = ~i_clk;
  // memory contents seen by reads
  assign rd_data = rd_addr[7:0] ^ 8'h3c;

  always @(posedge i_clk)
  begin
    if (rx_valid === 1'b1)
      rxq.push_back(rx_data);
    if (wr_en === 1'b1)
    begin
      n_wr++;
      wr_last = wr_addr;
    end
    if (cmd_err === 1'b1)
      n_err++;
  end

  function automatic logic [7:0] crc_of(input logic [55:0] d);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
    begin
      fb = c[0] ^ d[i];
      c = c >> 1;
      if (fb)
        c = c ^ 8'h8c;
    end
    return c;
  endfunction

  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic seq(input logic [7:0] q[$]);
    int k;
    foreach (q[i])
    begin
      tx_data <= q[i];
      tx_valid <= 1'b1;
      k = 0;
      @(posedge i_clk);
      while (tx_ready !== 1'b1 && k < 50)
      begin
        @(posedge i_clk);
        k++;
      end
      if (k == 50)
        check(16'h0, 16'h1, "tx stall");
    end
    tx_valid <= 1'b0;
    @(posedge i_clk);
  endtask

  // settle time lets stale stream bytes drain
  task automatic breset();
    bus_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    bus_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
    rxq.delete();
  endtask

  task automatic copy_case(input logic [15:0] a, input logic m, input int exp);
    int base;
    mission <= m;
    breset();
    seq('{swl_pkg::CMD_SKIP_ID, swl_pkg::CMD_WRITE_PAD, a[7:0], a[15:8], 8'h11, 8'h22});
    breset();
    base = n_wr;
    seq('{swl_pkg::CMD_RESUME, swl_pkg::CMD_COPY_PAD});
    repeat (10) @(posedge i_clk);
    check(16'(n_wr - base), 16'(exp), "copy writes");
  endtask

  task automatic rd_case(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    breset();
    seq('{swl_pkg::CMD_SKIP_ID, swl_pkg::CMD_READ_MEM, a[7:0], a[15:8]});
    repeat (8) @(posedge i_clk);
    check({8'h00, rxq[0]}, {8'h00, e0}, "read byte 0");
    check({8'h00, rxq[1]}, {8'h00, e1}, "read byte 1");
    check({15'h0, rd_req}, 16'h1, "read strobe");
  endtask

  initial
  begin
    id = {crc_of(ID_DATA), ID_DATA};
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    seq('{swl_pkg::CMD_READ_PAD});
    repeat (3) @(posedge i_clk);
    check(16'(n_err), 16'h1, "early memory cmd");
    breset();
    crc_clear <= 1'b1;
    @(posedge i_clk);
    crc_clear <= 1'b0;
    seq('{swl_pkg::CMD_READ_ID});
    repeat (16) @(posedge i_clk);
    check(16'(rxq.size()), 16'h8, "id length");
    for (int i = 0; i < 8; i++)
      check({8'h00, rxq[i]}, {8'h00, id[8*i+:8]}, "id byte");
    check({15'h0, crc_zero}, 16'h1, "crc residue");
    check({15'h0, id_ok}, 16'h1, "id done");
    check({15'h0, overdrive}, 16'h0, "speed");
    for (int bad = 0; bad < 2; bad++)
    begin
      breset();
      mq = '{(bad == 1) ? swl_pkg::CMD_OD_MATCH : swl_pkg::CMD_MATCH_ID};
      for (int i = 0; i < 8; i++)
        mq.push_back(id[8*i+:8] ^ ((bad == 1 && i == 3) ? 8'h01 : 8'h00));
      seq(mq);
      repeat (4) @(posedge i_clk);
      check({14'h0, overdrive, id_ok}, (bad == 1) ? 16'h0 : 16'h1, "match");
    end
    copy_case(16'h0010, 1'b0, 2);
    check(wr_last, 16'h0011, "copy address");
    copy_case(16'h1000, 1'b0, 0);
    copy_case(16'h0200, 1'b1, 0);
    copy_case(16'h0200, 1'b0, 2);
    mission <= 1'b0;
    rd_case(16'h0010, 8'h10 ^ 8'h3c, 8'h11 ^ 8'h3c);
    rd_case(16'h0228, 8'hff, 8'hff);
    breset();
    seq('{swl_pkg::CMD_OD_SKIP});
    repeat (3) @(posedge i_clk);
    check({14'h0, overdrive, id_ok}, 16'h3, "overdrive skip");
    breset();
    check({15'h0, overdrive}, 16'h1, "overdrive kept");
    stop_test();
  end

  initial
  begin
    #40000;
    mismatches++;
    $display("ERROR %0t timeout", $time);
    stop_test();
  end
endmodule
